//--- inc/mci_pkg.sv
package mci_pkg;
  // ****************************************
  // Frame layout and reply
  // ****************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  instr;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
    logic [7:0]  csum;
    logic        direct;
  } mci_frame_s;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] instr;
  } mci_reply_s;
  typedef enum logic {CTX_MAIN, CTX_HANDLER} mci_ctx_e;
  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [7:0] OP_ROT_POS   = 8'h01;
  localparam logic [7:0] OP_ROT_NEG   = 8'h02;
  localparam logic [7:0] OP_SOFT_HALT = 8'h03;
  localparam logic [7:0] OP_GP_WRITE  = 8'h09;
  localparam logic [7:0] OP_IRQ_EN    = 8'h19;
  localparam logic [7:0] OP_IRQ_DIS   = 8'h1A;
  localparam logic [7:0] OP_HPTR      = 8'h25;
  localparam logic [7:0] OP_HRET      = 8'h26;
  localparam logic [7:0] OP_ARITH_LO  = 8'h28;
  localparam logic [7:0] OP_ARITH_HI  = 8'h2D;
  localparam logic [7:0] OP_MOVE_ACCU = 8'h2E;
  localparam logic [7:0] OP_RESTART   = 8'h30;
  localparam logic [7:0] OP_DEC_BR    = 8'h31;
  localparam logic [7:0] OP_NEG_ACCU  = 8'h32;
  localparam logic [7:0] OP_POS_ACCU  = 8'h33;
  localparam logic [7:0] OP_IVAR_LO   = 8'h37;
  localparam logic [7:0] OP_IVAR_HI   = 8'h39;
  localparam logic [7:0] OP_COND_CALL = 8'h50;
  // ****************************************
  // Status codes, interrupts, revision
  // ****************************************
  localparam logic [7:0] STAT_OK      = 8'h64;
  localparam logic [7:0] STAT_CSUM    = 8'h01;
  localparam logic [7:0] STAT_BAD_CMD = 8'h02;
  localparam logic [7:0] IRQ_BANK     = 8'h03;
  localparam logic [7:0] FIRST_TIMER_IRQ_NUMBER = 8'h00;
  localparam logic [7:0] GLOBAL_IRQ_NUMBER      = 8'hFF;
  localparam int         NUM_TIMERS   = 3;
  localparam int         MIN_EXT_REV  = 146;
  // ****************************************
  // Timing
  // ****************************************
  localparam int TIMER_UNIT_NS = 1000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_CYCLES     = TIMER_UNIT_NS / CLK_PERIOD_NS;
  // ****************************************
  // Register map (byte offsets) and resets
  // ****************************************
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_TVEL   = 8'h04;
  localparam logic [7:0] OFS_ACCU   = 8'h08;
  localparam logic [7:0] OFS_XREG   = 8'h0C;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_IRQ    = 8'h14;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
endpackage

//--- hw/mci_top.sv
`timescale 1ns/100ps
module mci_top #(
  parameter int MS_CYCLES = mci_pkg::MS_CYCLES,
  parameter int FW_REV    = 146
) (
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               cmd_valid,
  input  mci_pkg::mci_frame_s     cmd_frame,
  output logic                    cmd_ready,
  output logic                    reply_valid,
  output mci_pkg::mci_reply_s     reply,
  output logic                    vel_mode,
  output logic                    vel_neg,
  output logic      [31:0]        target_vel,
  output logic                    move_req,
  output logic      [31:0]        move_pos,
  output logic                    ext_op_valid,
  output logic      [7:0]         ext_op,
  output logic                    irq_take,
  output logic      [1:0]         irq_num,
  output logic      [31:0]        irq_addr
);
  localparam int NT = mci_pkg::NUM_TIMERS;
  // ****************************************
  // State
  // ****************************************
  logic                  ack_reg, ack_next;
  logic [31:0]           rd_reg, rd_next;
  logic                  rv_reg, rv_next;
  mci_pkg::mci_reply_s   rp_reg, rp_next;
  logic                  vm_reg, vm_next;
  logic                  vn_reg, vn_next;
  logic [31:0]           tv_reg, tv_next;
  logic                  mv_reg, mv_next;
  logic [31:0]           mp_reg, mp_next;
  logic                  ev_reg, ev_next;
  logic [7:0]            eo_reg, eo_next;
  logic                  it_reg, it_next;
  logic [1:0]            in_reg, in_next;
  logic [31:0]           ia_reg, ia_next;
  logic [31:0]           accu_reg, accu_next;
  logic [31:0]           x_reg, x_next;
  logic [7:0]            flags_reg, flags_next;
  logic [31:0]           sv_accu_reg, sv_accu_next;
  logic [31:0]           sv_x_reg, sv_x_next;
  logic [7:0]            sv_flags_reg, sv_flags_next;
  mci_pkg::mci_ctx_e     ctx_reg, ctx_next;
  logic                  glob_reg, glob_next;
  logic [NT-1:0]         en_reg, en_next;
  logic [NT-1:0]         vok_reg, vok_next;
  logic [NT-1:0]         pend_reg, pend_next;
  logic [31:0]           handler_pointer_cmd_reg [NT];
  logic [31:0]           handler_pointer_cmd_next [NT];
  logic [31:0]           per_reg [NT];
  logic [31:0]           per_next [NT];
  logic [31:0]           tick_reg [NT];
  logic [31:0]           tick_next [NT];
  logic [31:0]           ms_reg, ms_next;
  // ****************************************
  // Decode
  // ****************************************
  logic       fire, csum_ok, is_ext, ext_ok, ms_tick, wb_req, take_c, ret_c;
  logic [7:0] sum8;
  logic [1:0] take_idx;
  logic [NT-1:0] expire, ready_irq;
  mci_pkg::mci_frame_s f;

  assign f         = cmd_frame;
  assign cmd_ready = !rv_reg;
  assign fire      = cmd_valid && cmd_ready;
  assign sum8      = 8'(f.addr + f.instr + f.typ + f.bank + f.value[31:24]
                     + f.value[23:16] + f.value[15:8] + f.value[7:0]);
  assign csum_ok   = (sum8 == f.csum);
  assign is_ext    = (f.instr >= mci_pkg::OP_ARITH_LO && f.instr <= mci_pkg::OP_MOVE_ACCU)
                  || (f.instr >= mci_pkg::OP_RESTART && f.instr <= mci_pkg::OP_POS_ACCU)
                  || (f.instr >= mci_pkg::OP_IVAR_LO && f.instr <= mci_pkg::OP_IVAR_HI)
                  || (f.instr == mci_pkg::OP_COND_CALL);
  assign ext_ok    = (FW_REV >= mci_pkg::MIN_EXT_REV);
  assign ms_tick   = (ms_reg == 32'(MS_CYCLES - 1));
  assign wb_req    = wb_cyc_i && wb_stb_i && !ack_reg;
  assign ret_c     = fire && csum_ok && f.instr == mci_pkg::OP_HRET && ctx_reg == mci_pkg::CTX_HANDLER;

  always_comb begin
    ready_irq = pend_reg & en_reg & vok_reg;
    take_c    = glob_reg && ctx_reg == mci_pkg::CTX_MAIN && |ready_irq;
    take_idx  = 2'h0;
    for (int i = NT - 1; i >= 0; i--) begin
      if (ready_irq[i]) begin
        take_idx = 2'(i);
      end
    end
  end
  // ****************************************
  // Millisecond timers
  // ****************************************
  always_comb begin
    ms_next = ms_tick ? 32'h0000_0000 : ms_reg + 32'h0000_0001;
    for (int i = 0; i < NT; i++) begin
      expire[i]    = 1'b0;
      tick_next[i] = tick_reg[i];
      if (per_reg[i] == 32'h0000_0000) begin
        tick_next[i] = 32'h0000_0000;
      end else if (ms_tick) begin
        if (tick_reg[i] + 32'h0000_0001 >= per_reg[i]) begin
          tick_next[i] = 32'h0000_0000;
          expire[i]    = 1'b1;
        end else begin
          tick_next[i] = tick_reg[i] + 32'h0000_0001;
        end
      end
    end
  end
  // ****************************************
  // Command and context next state
  // ****************************************
  always_comb begin
    rv_next = 1'b0;
    rp_next = rp_reg;
    vm_next = vm_reg;
    vn_next = vn_reg;
    tv_next = tv_reg;
    mv_next = 1'b0;
    mp_next = mp_reg;
    ev_next = 1'b0;
    eo_next = eo_reg;
    it_next = 1'b0;
    in_next = in_reg;
    ia_next = ia_reg;
    accu_next = accu_reg;
    x_next = x_reg;
    flags_next = flags_reg;
    sv_accu_next = sv_accu_reg;
    sv_x_next = sv_x_reg;
    sv_flags_next = sv_flags_reg;
    ctx_next = ctx_reg;
    glob_next = glob_reg;
    en_next = en_reg;
    vok_next = vok_reg;
    pend_next = pend_reg;
    for (int i = 0; i < NT; i++) begin
      handler_pointer_cmd_next[i] = handler_pointer_cmd_reg[i];
      per_next[i]  = per_reg[i];
    end
    // Software access to the program registers
    if (wb_req && wb_we_i) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b] && wb_adr_i == mci_pkg::OFS_ACCU) accu_next[8*b+:8] = wb_dat_i[8*b+:8];
        if (wb_sel_i[b] && wb_adr_i == mci_pkg::OFS_XREG) x_next[8*b+:8] = wb_dat_i[8*b+:8];
      end
      if (wb_sel_i[0] && wb_adr_i == mci_pkg::OFS_FLAGS) flags_next = wb_dat_i[7:0];
    end
    if (fire) begin
      rp_next.instr  = f.instr;
      rp_next.status = mci_pkg::STAT_OK;
      rv_next        = f.direct;
      if (!csum_ok) begin
        rp_next.status = mci_pkg::STAT_CSUM;
      end else if (is_ext && !ext_ok) begin
        rp_next.status = mci_pkg::STAT_BAD_CMD;
      end else if (is_ext) begin
        ev_next = 1'b1;
        eo_next = f.instr;
        if (f.instr == mci_pkg::OP_MOVE_ACCU) begin
          mv_next = 1'b1;
          mp_next = accu_reg;
        end
        if (f.instr == mci_pkg::OP_NEG_ACCU || f.instr == mci_pkg::OP_POS_ACCU) begin
          vm_next = 1'b1;
          vn_next = (f.instr == mci_pkg::OP_NEG_ACCU);
          tv_next = accu_reg;
        end
      end else begin
        unique case (f.instr)
          mci_pkg::OP_ROT_POS, mci_pkg::OP_ROT_NEG: begin
            vm_next = 1'b1;
            vn_next = (f.instr == mci_pkg::OP_ROT_NEG);
            tv_next = f.value;
          end
          mci_pkg::OP_SOFT_HALT: begin
            vm_next = 1'b1;
            tv_next = 32'h0000_0000;
          end
          mci_pkg::OP_HPTR: begin
            if (f.typ < 8'(NT)) begin
              handler_pointer_cmd_next[f.typ[1:0]] = f.value;
              vok_next[f.typ[1:0]]  = 1'b1;
            end
          end
          mci_pkg::OP_IRQ_EN, mci_pkg::OP_IRQ_DIS: begin
            if (f.typ == mci_pkg::GLOBAL_IRQ_NUMBER) begin
              glob_next = (f.instr == mci_pkg::OP_IRQ_EN);
            end else if (f.typ < 8'(NT)) begin
              en_next[f.typ[1:0]] = (f.instr == mci_pkg::OP_IRQ_EN);
            end
          end
          mci_pkg::OP_GP_WRITE: begin
            if (f.bank == mci_pkg::IRQ_BANK && f.typ < 8'(NT)) begin
              per_next[f.typ[1:0]] = f.value;
            end else begin
              rp_next.status = mci_pkg::STAT_BAD_CMD;
            end
          end
          mci_pkg::OP_HRET: begin
            if (ctx_reg == mci_pkg::CTX_HANDLER) begin
              ctx_next   = mci_pkg::CTX_MAIN;
              accu_next  = sv_accu_reg;
              x_next     = sv_x_reg;
              flags_next = sv_flags_reg;
            end
          end
          default: rp_next.status = mci_pkg::STAT_BAD_CMD;
        endcase
      end
    end
    if (take_c) begin
      it_next       = 1'b1;
      in_next       = take_idx;
      ia_next       = handler_pointer_cmd_reg[take_idx];
      ctx_next      = mci_pkg::CTX_HANDLER;
      sv_accu_next  = accu_reg;
      sv_x_next     = x_reg;
      sv_flags_next = flags_reg;
      pend_next[take_idx] = 1'b0;
    end
    pend_next = pend_next | expire;
  end
  // ****************************************
  // Wishbone slave
  // ****************************************
  always_comb begin
    ack_next = wb_req;
    rd_next  = rd_reg;
    if (wb_req) begin
      unique case (wb_adr_i)
        mci_pkg::OFS_STATUS: rd_next = {28'h0, ctx_reg == mci_pkg::CTX_HANDLER, glob_reg, vn_reg, vm_reg};
        mci_pkg::OFS_TVEL:   rd_next = tv_reg;
        mci_pkg::OFS_ACCU:   rd_next = accu_reg;
        mci_pkg::OFS_XREG:   rd_next = x_reg;
        mci_pkg::OFS_FLAGS:  rd_next = {24'h0, flags_reg};
        mci_pkg::OFS_IRQ:    rd_next = {24'h0, 1'b0, pend_reg, 1'b0, en_reg};
        default:             rd_next = mci_pkg::RST_WORD;
      endcase
    end
  end
  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      rd_reg <= mci_pkg::RST_WORD;
      rv_reg <= 1'b0;
      rp_reg <= '0;
      vm_reg <= 1'b0;
      vn_reg <= 1'b0;
      tv_reg <= mci_pkg::RST_WORD;
      mv_reg <= 1'b0;
      mp_reg <= mci_pkg::RST_WORD;
      ev_reg <= 1'b0;
      eo_reg <= 8'h00;
      it_reg <= 1'b0;
      in_reg <= 2'h0;
      ia_reg <= mci_pkg::RST_WORD;
      accu_reg <= mci_pkg::RST_WORD;
      x_reg <= mci_pkg::RST_WORD;
      flags_reg <= 8'h00;
      sv_accu_reg <= mci_pkg::RST_WORD;
      sv_x_reg <= mci_pkg::RST_WORD;
      sv_flags_reg <= 8'h00;
      ctx_reg <= mci_pkg::CTX_MAIN;
      glob_reg <= 1'b0;
      en_reg <= '0;
      vok_reg <= '0;
      pend_reg <= '0;
      ms_reg <= mci_pkg::RST_WORD;
      for (int i = 0; i < NT; i++) begin
        handler_pointer_cmd_reg[i] <= mci_pkg::RST_WORD;
        per_reg[i] <= mci_pkg::RST_WORD;
        tick_reg[i] <= mci_pkg::RST_WORD;
      end
    end else begin
      ack_reg <= ack_next;
      rd_reg <= rd_next;
      rv_reg <= rv_next;
      rp_reg <= rp_next;
      vm_reg <= vm_next;
      vn_reg <= vn_next;
      tv_reg <= tv_next;
      mv_reg <= mv_next;
      mp_reg <= mp_next;
      ev_reg <= ev_next;
      eo_reg <= eo_next;
      it_reg <= it_next;
      in_reg <= in_next;
      ia_reg <= ia_next;
      accu_reg <= accu_next;
      x_reg <= x_next;
      flags_reg <= flags_next;
      sv_accu_reg <= sv_accu_next;
      sv_x_reg <= sv_x_next;
      sv_flags_reg <= sv_flags_next;
      ctx_reg <= ctx_next;
      glob_reg <= glob_next;
      en_reg <= en_next;
      vok_reg <= vok_next;
      pend_reg <= pend_next;
      ms_reg <= ms_next;
      handler_pointer_cmd_reg <= handler_pointer_cmd_next;
      per_reg <= per_next;
      tick_reg <= tick_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;
  assign reply_valid = rv_reg;
  assign reply = rp_reg;
  assign vel_mode = vm_reg;
  assign vel_neg = vn_reg;
  assign target_vel = tv_reg;
  assign move_req = mv_reg;
  assign move_pos = mp_reg;
  assign ext_op_valid = ev_reg;
  assign ext_op = eo_reg;
  assign irq_take = it_reg;
  assign irq_num = in_reg;
  assign irq_addr = ia_reg;
  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic good;
  assign good = fire && csum_ok;
  a_rot_pos_mode: assert property (good && f.instr == 8'h01 |=> vel_mode && !vel_neg) else $error("pos rotate");
  a_rot_neg_mode: assert property (good && f.instr == 8'h02 |=> vel_mode && vel_neg) else $error("neg rotate");
  a_vel_msb_first: assert property (good && f.instr == 8'h01 |=> target_vel[31:24] == $past(f.value[31:24]))
    else $error("velocity byte order");
  a_soft_stop_zero: assert property (good && f.instr == 8'h03 |=> vel_mode && target_vel == 32'h0)
    else $error("soft stop");
  a_fields_ignored: assert property (good && f.instr == 8'h02 && f.bank != 8'h0 |=> vel_neg)
    else $error("bank not ignored");
  a_irq_gate: assert property (irq_take |-> $past(glob_reg) && $past(en_reg[take_idx])) else $error("ungated irq");
  a_no_nesting: assert property (ctx_reg == mci_pkg::CTX_HANDLER |=> !irq_take) else $error("nested irq");
  a_ctx_restore: assert property (ret_c |=> accu_reg == $past(sv_accu_reg) && x_reg == $past(sv_x_reg))
    else $error("context not restored");
  a_ms_bound: assert property (ms_reg < 32'(MS_CYCLES)) else $error("ms prescaler overrun");
  a_global_num: assert property (good && f.instr == 8'h19 && f.typ == 8'hFF |=> glob_reg) else $error("global en");
  a_ext_gate: assert property (good && is_ext |=> ext_op_valid == ext_ok) else $error("revision gate");
  a_csum_reply: assert property (fire && !csum_ok && f.direct |=> reply_valid && reply.status == 8'h01)
    else $error("checksum reply");
  a_ok_reply: assert property (good && f.direct && f.instr == 8'h03 |=> reply_valid && reply.status == 8'h64)
    else $error("ok reply");
  c_rotate: cover property (good && f.instr == 8'h01 ##1 reply_valid);
  c_irq_cycle: cover property (irq_take ##[1:1000] ret_c);
  c_accu_move: cover property (move_req);
endmodule

//--- verif/mci_host.sv
`timescale 1ns/100ps
// ****************************************
// Host model driving command frames
// ****************************************
module mci_host (
  input  wire logic          core_clk,
  input  wire logic          cmd_ready,
  output logic               cmd_valid,
  output mci_pkg::mci_frame_s cmd_frame
);
  initial begin
    cmd_valid = 1'b0;
    cmd_frame = '0;
  end
  // Bad flag corrupts the checksum on purpose
  task automatic send(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] bank,
                      input logic [31:0] val, input logic bad);
    mci_pkg::mci_frame_s f;
    f = '{8'h01, op, typ, bank, val, 8'h00, 1'b1};
    f.csum = 8'(f.addr + op + typ + bank + val[31:24] + val[23:16] + val[15:8] + val[7:0] + bad);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_frame <= f;
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    cmd_frame <= ~f;
  endtask
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module testbench;
  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] val;
    logic        bad;
    logic [7:0]  st;
    logic        neg;
    logic [31:0] tv;
  } mci_row_s;
  logic                core_clk = 1'b0;
  logic                rstn     = 1'b0;
  logic                wb_cyc_i = 1'b0;
  logic                wb_stb_i = 1'b0;
  logic                wb_we_i  = 1'b0;
  logic [7:0]          wb_adr_i = 8'h00;
  logic [3:0]          wb_sel_i = 4'h0;
  logic [31:0]         wb_dat_i = 32'h0;
  logic [31:0]         wb_dat_o, target_vel, move_pos, irq_addr, rd;
  logic                wb_ack_o, cmd_valid, cmd_ready, reply_valid, vel_mode, vel_neg;
  logic                move_req, ext_op_valid, irq_take, mv, ev, seen;
  logic [7:0]          ext_op, st, eo;
  logic [1:0]          irq_num;
  mci_pkg::mci_frame_s cmd_frame;
  mci_pkg::mci_reply_s reply;
  int                  miscompares = 0;
  int                  num_checks  = 0;
  mci_row_s            rows [8] = '{
    '{8'h01, 8'h00, 8'h00, 32'h0000C800, 1'b0, 8'h64, 1'b0, 32'h0000C800},
    '{8'h02, 8'h00, 8'h00, 32'h0000C800, 1'b0, 8'h64, 1'b1, 32'h0000C800},
    '{8'h01, 8'h00, 8'h00, 32'h80000000, 1'b0, 8'h64, 1'b0, 32'h80000000},
    '{8'h03, 8'h00, 8'h00, 32'h00000000, 1'b0, 8'h64, 1'b0, 32'h00000000},
    '{8'h02, 8'h05, 8'h07, 32'h01020304, 1'b0, 8'h64, 1'b1, 32'h01020304},
    '{8'h01, 8'h00, 8'h00, 32'h00000777, 1'b1, 8'h01, 1'b1, 32'h01020304},
    '{8'h04, 8'h00, 8'h00, 32'h00000000, 1'b0, 8'h02, 1'b1, 32'h01020304},
    '{8'h09, 8'h00, 8'h00, 32'h00000005, 1'b0, 8'h02, 1'b1, 32'h01020304}};
  logic [7:0]          ext_ops [12] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D,
                                        8'h30, 8'h31, 8'h37, 8'h38, 8'h39, 8'h50};

  always #12.5 core_clk = ~core_clk;

  mci_top #(.MS_CYCLES(4), .FW_REV(146)) mci_top_i (
    .core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_valid(cmd_valid), .cmd_frame(cmd_frame),
    .cmd_ready(cmd_ready), .reply_valid(reply_valid), .reply(reply), .vel_mode(vel_mode),
    .vel_neg(vel_neg), .target_vel(target_vel), .move_req(move_req), .move_pos(move_pos),
    .ext_op_valid(ext_op_valid), .ext_op(ext_op), .irq_take(irq_take), .irq_num(irq_num),
    .irq_addr(irq_addr));
  mci_host mci_host_i (.core_clk(core_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
    .cmd_frame(cmd_frame));

  // ****************************************
  // Bus and frame tasks
  // ****************************************
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Captures reply and pulses at the reply edge
  task automatic xfer(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] bank,
                      input logic [31:0] val, input logic bad);
    mci_host_i.send(op, typ, bank, val, bad);
    do @(posedge core_clk); while (reply_valid !== 1'b1);
    st = reply.status;
    mv = move_req;
    ev = ext_op_valid;
    eo = ext_op;
  endtask
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n) begin @(posedge core_clk); seen = seen | (irq_take === 1'b1); end
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge core_clk);
    miscompares++;
    give_verdict;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    `CHK("vel_mode rst", 1'b0, vel_mode)
    `CHK("cmd_ready rst", 1'b1, cmd_ready)
    foreach (rows[i]) begin
      xfer(rows[i].op, rows[i].typ, rows[i].bank, rows[i].val, rows[i].bad);
      `CHK("status", rows[i].st, st)
      `CHK("reply instr", rows[i].op, reply.instr)
      `CHK("vel_mode", 1'b1, vel_mode)
      `CHK("vel_neg", rows[i].neg, vel_neg)
      `CHK("target_vel", rows[i].tv, target_vel)
    end
    wb(1'b0, 8'h00, 32'h0);
    `CHK("status reg", 2'b11, rd[1:0])
    wb(1'b1, 8'h04, 32'hFFFFFFFF);
    wb(1'b0, 8'h04, 32'h0);
    `CHK("tvel reg", 32'h01020304, rd)
    wb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    wb(1'b1, 8'h08, 32'h00001234);
    xfer(8'h33, 8'h00, 8'h00, 32'h0, 1'b0);
    `CHK("pos accu vel", 32'h00001234, target_vel)
    `CHK("pos accu dir", 1'b0, vel_neg)
    xfer(8'h32, 8'h00, 8'h00, 32'h0, 1'b0);
    `CHK("neg accu dir", 1'b1, vel_neg)
    xfer(8'h2E, 8'h00, 8'h00, 32'h0, 1'b0);
    `CHK("move_req", 1'b1, mv)
    `CHK("move_pos", 32'h00001234, move_pos)
    foreach (ext_ops[i]) begin
      xfer(ext_ops[i], 8'h00, 8'h00, 32'h0, 1'b0);
      `CHK("ext_op_valid", 1'b1, ev)
      `CHK("ext_op", ext_ops[i], eo)
    end
    wb(1'b1, 8'h08, 32'h00001234);
    xfer(8'h25, 8'h00, 8'h00, 32'h00000100, 1'b0);
    xfer(8'h09, 8'h00, 8'h03, 32'h00000002, 1'b0);
    xfer(8'h19, 8'h00, 8'h00, 32'h0, 1'b0);
    watch(30);
    `CHK("no irq w/o global", 1'b0, seen)
    xfer(8'h19, 8'hFF, 8'h00, 32'h0, 1'b0);
    watch(20);
    `CHK("irq taken", 1'b1, seen)
    `CHK("irq_num", 2'd0, irq_num)
    `CHK("irq_addr", 32'h00000100, irq_addr)
    watch(40);
    `CHK("no nesting", 1'b0, seen)
    wb(1'b0, 8'h00, 32'h0);
    `CHK("in handler", 1'b1, rd[3])
    wb(1'b1, 8'h08, 32'h0000AAAA);
    xfer(8'h26, 8'h00, 8'h00, 32'h0, 1'b0);
    wb(1'b0, 8'h08, 32'h0);
    `CHK("accu restored", 32'h00001234, rd)
    wb(1'b0, 8'h14, 32'h0);
    `CHK("irq enable set", 3'b001, rd[2:0])
    xfer(8'h1A, 8'h00, 8'h00, 32'h0, 1'b0);
    `CHK("disable status", 8'h64, st)
    wb(1'b0, 8'h14, 32'h0);
    `CHK("irq enable clr", 3'b000, rd[2:0])
    // Reset in mid-run
    @(posedge core_clk);
    rstn <= 1'b0;
    @(posedge core_clk);
    `CHK("vel_mode mid rst", 1'b0, vel_mode)
    `CHK("target_vel mid rst", 32'h0, target_vel)
    `CHK("irq_addr mid rst", 32'h0, irq_addr)
    `CHK("cmd_ready mid rst", 1'b1, cmd_ready)
    rstn <= 1'b1;
    xfer(8'h01, 8'h00, 8'h00, 32'h0000C800, 1'b0);
    `CHK("rotate after rst", 32'h0000C800, target_vel)
    `CHK("dir after rst", 1'b0, vel_neg)
    give_verdict;
  end
endmodule
